// *** pull_cfg_map.svh ***
`ifndef PULL_CFG_MAP_SVH
`define PULL_CFG_MAP_SVH

// ****************************************************************
// register indices (byte address = index * 4)
// ****************************************************************
`define IDX_UPPER_INPUT_LEVEL 6'h18
`define IDX_ROW_LOW_PULL_SELECT 6'h19
`define IDX_ROW_HIGH_PULL_SELECT 6'h1a
`define IDX_COLUMN_LOW_PULL_SELECT 6'h1b
`define IDX_COLUMN_MID_PULL_SELECT 6'h1c
`define IDX_PULL_FIRST 6'h19
`define IDX_PULL_LAST 6'h1c

// ****************************************************************
// field layout
// ****************************************************************
`define UPPER_LEVEL_WIDTH 3
`define PULL_FIELD_WIDTH 2
`define PULL_PIN_COUNT 16

// ****************************************************************
// pull selection codes
// ****************************************************************
`define PULL_CODE_UP_WEAK 2'b00
`define PULL_CODE_DOWN 2'b01
`define PULL_CODE_UP_STRONG 2'b10
`define PULL_CODE_OFF 2'b11

// ****************************************************************
// reset values, standard and alternate variants
// ****************************************************************
`define RST_ROW_LOW_STD 8'h00
`define RST_ROW_HIGH_STD 8'h00
`define RST_COLUMN_LOW_STD 8'h00
`define RST_COLUMN_MID_STD 8'h00
`define RST_ROW_LOW_ALT 8'h41
`define RST_ROW_HIGH_ALT 8'h01
`define RST_COLUMN_LOW_ALT 8'h00
`define RST_COLUMN_MID_ALT 8'h11

`endif

// *** pull_cfg_pkg.sv ***
`include "pull_cfg_map.svh"

package pull_cfg_pkg;

	// pull resistor selection per pin
	typedef enum logic [1:0] {
		PULL_UP_WEAK = `PULL_CODE_UP_WEAK,
		PULL_DOWN = `PULL_CODE_DOWN,
		PULL_UP_STRONG = `PULL_CODE_UP_STRONG,
		PULL_OFF = `PULL_CODE_OFF
	} pull_mode_t;

	// bus phase, gray along idle -> access
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_ACCESS = 2'b01
	} apb_phase_t;

endpackage

// *** pull_decode.sv ***
`timescale 1ns/1ps

module pull_decode (
	input wire pull_cfg_pkg::pull_mode_t mode,
	output logic up_weak,
	output logic down,
	output logic up_strong
);
	import pull_cfg_pkg::*;

	// one-hot enables, off code asserts none
	always_comb begin
		up_weak = 1'b0;
		down = 1'b0;
		up_strong = 1'b0;
		case (mode)
			PULL_UP_WEAK: up_weak = 1'b1;
			PULL_DOWN: down = 1'b1;
			PULL_UP_STRONG: up_strong = 1'b1;
			default: up_weak = 1'b0;
		endcase
	end
endmodule

// *** level_capture.sv ***
`timescale 1ns/1ps

module level_capture #(
	parameter int WIDTH = 3
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] pin_level,
	output logic [WIDTH-1:0] level_q
);
	logic [WIDTH-1:0] level_ff;
	logic [WIDTH-1:0] nxt_level;

	// live pin level, taken every cycle
	always_comb begin
		nxt_level = pin_level;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			level_ff <= '0;
		end else begin
			level_ff <= nxt_level;
		end
	end

	assign level_q = level_ff;
endmodule

// *** input_level_and_pull_config.sv ***
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "pull_cfg_map.svh"

module input_level_and_pull_config #(
	parameter bit ALT_VARIANT = 1'b0,
	parameter int ADDR_W = 8
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic column_line_8,
	input wire logic column_line_9,
	input wire logic column_line_10,
	output logic [7:0] row_pull_up_weak,
	output logic [7:0] row_pull_down,
	output logic [7:0] row_pull_up_strong,
	output logic [7:0] column_pull_up_weak,
	output logic [7:0] column_pull_down,
	output logic [7:0] column_pull_up_strong
);
	import pull_cfg_pkg::*;

	// ****************************************************************
	// reset image of the four pull registers
	// ****************************************************************
	localparam logic [31:0] RST_STD = {`RST_COLUMN_MID_STD, `RST_COLUMN_LOW_STD,
		`RST_ROW_HIGH_STD, `RST_ROW_LOW_STD};
	localparam logic [31:0] RST_ALT = {`RST_COLUMN_MID_ALT, `RST_COLUMN_LOW_ALT,
		`RST_ROW_HIGH_ALT, `RST_ROW_LOW_ALT};
	localparam logic [31:0] RST_ALL = ALT_VARIANT ? RST_ALT : RST_STD;
	localparam int PINS = `PULL_PIN_COUNT;

	// ****************************************************************
	// declarations
	// ****************************************************************
	apb_phase_t phase_ff;
	apb_phase_t nxt_phase;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic pready_ff;
	logic nxt_pready;
	logic pslverr_ff;
	logic nxt_pslverr;
	logic [31:0] pull_cfg_ff;
	logic [31:0] nxt_pull_cfg;
	logic [PINS-1:0] up_weak_ff;
	logic [PINS-1:0] down_ff;
	logic [PINS-1:0] up_strong_ff;
	logic [PINS-1:0] nxt_up_weak;
	logic [PINS-1:0] nxt_down;
	logic [PINS-1:0] nxt_up_strong;
	logic [`UPPER_LEVEL_WIDTH-1:0] upper_level;
	logic [5:0] word_idx;
	logic aligned;
	logic hit_level;
	logic hit_pull;
	logic [1:0] pull_sel;
	logic wr_fire;

	// ****************************************************************
	// pin level sampling
	// ****************************************************************
	level_capture #(
		.WIDTH(`UPPER_LEVEL_WIDTH)
	) u_level (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.pin_level({column_line_10, column_line_9, column_line_8}),
		.level_q(upper_level)
	);

	// ****************************************************************
	// address decode
	// ****************************************************************
	// word index from byte address, misaligned goes unmapped
	always_comb begin
		word_idx = 6'(paddr >> 2);
		aligned = (paddr[1:0] == 2'b00) && ((paddr >> 8) == '0);
		hit_level = aligned && (word_idx == `IDX_UPPER_INPUT_LEVEL);
		hit_pull = aligned && (word_idx >= `IDX_PULL_FIRST) && (word_idx <= `IDX_PULL_LAST);
		pull_sel = 2'(word_idx - `IDX_PULL_FIRST);
	end

	// write takes effect only at the completing access edge
	assign wr_fire = (phase_ff == PH_ACCESS) && psel && penable && pwrite && pready_ff;

	// ****************************************************************
	// bus phase, read data and error response
	// ****************************************************************
	// read data latched in setup so the access cycle sees a registered value
	always_comb begin
		nxt_phase = phase_ff;
		nxt_prdata = prdata_ff;
		nxt_pready = 1'b0;
		nxt_pslverr = 1'b0;
		case (phase_ff)
			PH_IDLE: begin
				if (psel && !penable) begin
					nxt_phase = PH_ACCESS;
					nxt_pready = 1'b1;
					nxt_pslverr = !(hit_level || hit_pull);
					nxt_prdata = 32'h0000_0000;
					if (!pwrite && hit_level) begin
						nxt_prdata = 32'({upper_level});
					end else if (!pwrite && hit_pull) begin
						nxt_prdata = 32'(pull_cfg_ff[pull_sel*8 +: 8]);
					end
				end
			end
			PH_ACCESS: begin
				nxt_phase = PH_IDLE;
			end
			default: begin
				nxt_phase = PH_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			phase_ff <= PH_IDLE;
			prdata_ff <= 32'h0000_0000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			phase_ff <= nxt_phase;
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;

	// ****************************************************************
	// pull selection registers
	// ****************************************************************
	// byte lane 0 carries the 8-bit register; level register takes no write
	always_comb begin
		nxt_pull_cfg = pull_cfg_ff;
		if (wr_fire && hit_pull && pstrb[0]) begin
			nxt_pull_cfg[pull_sel*8 +: 8] = pwdata[7:0];
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pull_cfg_ff <= RST_ALL;
		end else begin
			pull_cfg_ff <= nxt_pull_cfg;
		end
	end

	// ****************************************************************
	// per pin decode, rows 0..7 then columns 0..7
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < PINS; g++) begin : gen_pin
			localparam logic [1:0] RST_CODE = RST_ALL[2*g +: 2];

			// decode of next field so enables move with the register
			pull_decode u_dec (
				.mode(pull_mode_t'(nxt_pull_cfg[2*g +: 2])),
				.up_weak(nxt_up_weak[g]),
				.down(nxt_down[g]),
				.up_strong(nxt_up_strong[g])
			);

			always_ff @(posedge clk_sys or negedge resetn) begin
				if (!resetn) begin
					up_weak_ff[g] <= (RST_CODE == `PULL_CODE_UP_WEAK);
					down_ff[g] <= (RST_CODE == `PULL_CODE_DOWN);
					up_strong_ff[g] <= (RST_CODE == `PULL_CODE_UP_STRONG);
				end else begin
					up_weak_ff[g] <= nxt_up_weak[g];
					down_ff[g] <= nxt_down[g];
					up_strong_ff[g] <= nxt_up_strong[g];
				end
			end

			// enables match the stored code
			mode_on_a: assert property (@(posedge clk_sys) disable iff (!resetn)
				(pull_cfg_ff[2*g +: 2] != `PULL_CODE_OFF) |->
				(up_weak_ff[g] == (pull_cfg_ff[2*g +: 2] == `PULL_CODE_UP_WEAK)) &&
				(down_ff[g] == (pull_cfg_ff[2*g +: 2] == `PULL_CODE_DOWN)) &&
				(up_strong_ff[g] == (pull_cfg_ff[2*g +: 2] == `PULL_CODE_UP_STRONG)))
				else $error("pull enable does not match field code");

			mode_off_a: assert property (@(posedge clk_sys) disable iff (!resetn)
				(pull_cfg_ff[2*g +: 2] == `PULL_CODE_OFF) |->
				!(up_weak_ff[g] || down_ff[g] || up_strong_ff[g]))
				else $error("pull enable active while field is off");
		end
	endgenerate

	// pin outputs straight from the enable flops
	assign row_pull_up_weak = up_weak_ff[7:0];
	assign row_pull_down = down_ff[7:0];
	assign row_pull_up_strong = up_strong_ff[7:0];
	assign column_pull_up_weak = up_weak_ff[15:8];
	assign column_pull_down = down_ff[15:8];
	assign column_pull_up_strong = up_strong_ff[15:8];

	// ****************************************************************
	// checks
	// ****************************************************************
	// read of level register returns pins two edges back
	level_tracks_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(phase_ff == PH_ACCESS && !pwrite && hit_level && $past(resetn, 2)) |->
		prdata_ff[2:0] == $past({column_line_10, column_line_9, column_line_8}, 2))
		else $error("level read does not match column pins");

	reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(pready_ff && !pwrite && hit_level) |-> (prdata_ff[31:3] == '0) && !pslverr_ff)
		else $error("reserved level bits not zero");

	row_low_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(wr_fire && pstrb[0] && word_idx == `IDX_ROW_LOW_PULL_SELECT && aligned) |=>
		pull_cfg_ff[7:0] == $past(pwdata[7:0]))
		else $error("row low pull write lost");

	row_high_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(wr_fire && pstrb[0] && word_idx == `IDX_ROW_HIGH_PULL_SELECT && aligned) |=>
		(pull_cfg_ff[15:8] == $past(pwdata[7:0])) && $stable(pull_cfg_ff[7:0]))
		else $error("row high pull write lost");

	col_low_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(wr_fire && pstrb[0] && word_idx == `IDX_COLUMN_LOW_PULL_SELECT && aligned) |=>
		(pull_cfg_ff[23:16] == $past(pwdata[7:0])) && (column_pull_down[0] ==
		($past(pwdata[1:0]) == `PULL_CODE_DOWN)))
		else $error("column low pull write lost");

	col_mid_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(wr_fire && pstrb[0] && word_idx == `IDX_COLUMN_MID_PULL_SELECT && aligned) |=>
		(pull_cfg_ff[31:24] == $past(pwdata[7:0])) && (column_pull_up_strong[7] ==
		($past(pwdata[7:6]) == `PULL_CODE_UP_STRONG)))
		else $error("column mid pull write lost");

	std_reset_a: assert property (@(posedge clk_sys)
		(!resetn && !ALT_VARIANT) |-> (pull_cfg_ff == 32'h0000_0000) && (&up_weak_ff))
		else $error("standard pull reset value wrong");

	alt_reset_a: assert property (@(posedge clk_sys)
		(!resetn && ALT_VARIANT) |-> (pull_cfg_ff[7:0] == `RST_ROW_LOW_ALT) &&
		row_pull_down[3] && row_pull_down[0])
		else $error("alternate row pull reset value wrong");

	status_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(wr_fire && hit_level) |=> $stable(pull_cfg_ff) && !$past(pslverr_ff))
		else $error("level register write disturbed state");

	outputs_follow_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(wr_fire && pstrb[0] && word_idx == `IDX_ROW_LOW_PULL_SELECT && aligned) |=>
		(row_pull_down[0] == ($past(pwdata[1:0]) == `PULL_CODE_DOWN)) &&
		(row_pull_up_weak[3] == ($past(pwdata[7:6]) == `PULL_CODE_UP_WEAK)))
		else $error("pull enable late after write");

	// reads and refused writes leave the pull state alone
	status_read_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(pready_ff && !pwrite && hit_level) |=> $stable(pull_cfg_ff))
		else $error("level register read disturbed state");

	dropped_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(wr_fire && (!pstrb[0] || !aligned)) |=> $stable(pull_cfg_ff) &&
		$stable(up_weak_ff) && $stable(down_ff) && $stable(up_strong_ff))
		else $error("refused write changed pull state");

	write_pull_c: cover property (@(posedge clk_sys) disable iff (!resetn)
		wr_fire && hit_pull && pwdata[1:0] == `PULL_CODE_OFF);

	read_level_c: cover property (@(posedge clk_sys) disable iff (!resetn)
		pready_ff && !pwrite && hit_level && prdata_ff[2:0] == 3'h5);

	unmapped_c: cover property (@(posedge clk_sys) disable iff (!resetn)
		pready_ff && pslverr_ff);

	level_write_c: cover property (@(posedge clk_sys) disable iff (!resetn)
		wr_fire && hit_level);

	dropped_write_c: cover property (@(posedge clk_sys) disable iff (!resetn)
		wr_fire && (!pstrb[0] || !aligned));
endmodule

// *** switch_model.sv ***
`timescale 1ns/1ps

// ****************************************************************
// far side: switches on the upper column lines
// ****************************************************************
module switch_model (
	input wire logic [2:0] want,
	output logic column_line_8,
	output logic column_line_9,
	output logic column_line_10
);
	// each switch drives its line hard to the requested level
	assign column_line_8 = want[0];
	assign column_line_9 = want[1];
	assign column_line_10 = want[2];
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
`include "pull_cfg_map.svh"

module testbench;
	import pull_cfg_pkg::*;
	logic clk_sys = 1'b0;
	logic resetn = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [2:0] want = 3'h0;
	logic column_line_8;
	logic column_line_9;
	logic column_line_10;
	logic [7:0] rw, rd, rs, cw, cd, cs;
	logic [7:0] alt_rw, alt_rd;
	logic [31:0] prdata_alt;
	logic [31:0] rdata_alt;
	logic [7:0] img [4];
	logic [7:0] v;
	logic [31:0] rdata;
	logic rerr;
	int seed = 46;
	int mismatches = 0;
	int total_checks = 0;
	localparam logic [7:0] LVL = {`IDX_UPPER_INPUT_LEVEL, 2'b00};

	// ****************************************************************
	// clock, dut and far side
	// ****************************************************************
	always #5 clk_sys = ~clk_sys;

	input_level_and_pull_config u_dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .column_line_8(column_line_8),
		.column_line_9(column_line_9), .column_line_10(column_line_10),
		.row_pull_up_weak(rw), .row_pull_down(rd), .row_pull_up_strong(rs),
		.column_pull_up_weak(cw), .column_pull_down(cd), .column_pull_up_strong(cs));

	switch_model u_sw (.want(want), .column_line_8(column_line_8),
		.column_line_9(column_line_9), .column_line_10(column_line_10));

	// alternate reset variant on the same bus
	input_level_and_pull_config #(.ALT_VARIANT(1'b1)) u_dut_alt (.clk_sys(clk_sys),
		.resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata_alt), .pready(), .pslverr(),
		.column_line_8(column_line_8), .column_line_9(column_line_9),
		.column_line_10(column_line_10), .row_pull_up_weak(alt_rw), .row_pull_down(alt_rd),
		.row_pull_up_strong(), .column_pull_up_weak(), .column_pull_down(),
		.column_pull_up_strong());

	// ****************************************************************
	// helpers
	// ****************************************************************
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task complete_run;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// one apb transfer, idle cycle before setup
	task apb(input logic wr, input logic [7:0] addr, input logic [31:0] data,
		input logic [3:0] strb);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		pstrb <= strb;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			mismatches++;
			$display("Error pready expected 1 seen %b", pready);
			complete_run();
		end else begin
			rdata = prdata;
			rdata_alt = prdata_alt;
			rerr = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	function automatic logic [7:0] pull_addr(input int k);
		return 8'((`IDX_ROW_LOW_PULL_SELECT + k) * 4);
	endfunction

	// per pin enable expected from two field registers
	function automatic logic [7:0] exp_en(input logic [7:0] lo, input logic [7:0] hi,
		input logic [1:0] code);
		logic [7:0] r;
		for (int i = 0; i < 4; i++) begin
			r[i] = (lo[2*i+:2] == code);
			r[i+4] = (hi[2*i+:2] == code);
		end
		return r;
	endfunction

	task check_pins;
		@(negedge clk_sys); // enables move at the write edge, look once settled
		check("row weak up", 32'(rw), 32'(exp_en(img[0], img[1], `PULL_CODE_UP_WEAK)));
		check("row down", 32'(rd), 32'(exp_en(img[0], img[1], `PULL_CODE_DOWN)));
		check("row strong up", 32'(rs), 32'(exp_en(img[0], img[1], `PULL_CODE_UP_STRONG)));
		check("col weak up", 32'(cw), 32'(exp_en(img[2], img[3], `PULL_CODE_UP_WEAK)));
		check("col down", 32'(cd), 32'(exp_en(img[2], img[3], `PULL_CODE_DOWN)));
		check("col strong up", 32'(cs), 32'(exp_en(img[2], img[3], `PULL_CODE_UP_STRONG)));
	endtask

	// ****************************************************************
	// watchdog
	// ****************************************************************
	initial begin
		repeat (20000) @(posedge clk_sys);
		mismatches++;
		$display("Error watchdog expected finish seen hang");
		complete_run();
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		resetn <= 1'b0;
		repeat (20) @(posedge clk_sys);
		resetn <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			img[k] = 8'h00;
			apb(1'b0, pull_addr(k), 32'h0000_0000, 4'h0);
			check("pull reset", rdata, {24'h00_0000, img[k]});
			if (k == 0) begin
				check("alt row low reset", rdata_alt, {24'h00_0000, `RST_ROW_LOW_ALT});
			end
		end
		check_pins();
		v = exp_en(`RST_ROW_LOW_ALT, `RST_ROW_HIGH_ALT, `PULL_CODE_DOWN);
		check("alt row down", 32'(alt_rd), 32'(v));
		v = exp_en(`RST_ROW_LOW_ALT, `RST_ROW_HIGH_ALT, `PULL_CODE_UP_WEAK);
		check("alt row weak up", 32'(alt_rw), 32'(v));
		$display("test reset done");
		repeat (8) begin
			want <= 3'($random(seed));
			repeat (3) @(posedge clk_sys);
			apb(1'b0, LVL, 32'h0000_0000, 4'h0);
			check("level", rdata, {29'h0000_0000, want});
			check("level err", 32'(rerr), 32'h0000_0000);
		end
		apb(1'b1, LVL, 32'hffff_ffff, 4'hf);
		apb(1'b0, LVL, 32'h0000_0000, 4'h0);
		check("level after write", rdata, {29'h0000_0000, want});
		check_pins();
		$display("test level done");
		for (int i = 0; i < 12; i++) begin
			for (int k = 0; k < 4; k++) begin
				case (i)
					0: v = 8'h55;
					1: v = 8'haa;
					2: v = 8'hff;
					3: v = 8'h1b;
					default: v = 8'($random(seed));
				endcase
				apb(1'b1, pull_addr(k), {24'($random(seed)), v}, 4'hf);
				img[k] = v;
				check_pins();
			end
			for (int k = 0; k < 4; k++) begin
				apb(1'b0, pull_addr(k), 32'h0000_0000, 4'h0);
				check("pull readback", rdata, {24'h00_0000, img[k]});
			end
		end
		$display("test pull done");
		apb(1'b1, pull_addr(0), 32'h0000_00e4, 4'h0);
		apb(1'b1, pull_addr(1) + 8'h01, 32'h0000_00e4, 4'hf);
		check("misaligned err", 32'(rerr), 32'h0000_0001);
		apb(1'b0, 8'h74, 32'h0000_0000, 4'h0);
		check("unmapped err", 32'(rerr), 32'h0000_0001);
		check("unmapped data", rdata, 32'h0000_0000);
		check_pins();
		$display("test refusal done");
		complete_run();
	end
endmodule
